// file: hdl/rotir_pkg.sv
// Constants and types of the trim scheduler and interrupt router.
// Assumes an APB master on the register side and event logic on the same clock.
//
// Summary of operation
// - Slow trim: start run every fourth hour
// - Slow pulses per minute from minute 00
// - Fast trim: start run at every eighth minute from 08 to 56
// - Fast pulses per second from second 00
// - Trim pulse gives interrupt pulse when enabled
// - Two outputs, each with own enable
// - First output open drain, mode field gated
// - Second output push-pull on capture pin
// - Outputs active low, only in interrupt mode
// - Enable register bit layout, all reset zero
// - Mode bit: zero pulse, one level
// - Each trigger gives fresh pulse regardless flag
// - Triggers from all seven sources recognised
// - Pulse cleared by 128 Hz, one-two periods
// - Clearing flag ends pulse early
// - Level output is OR of enabled flags
// - Monitor bit shows any flag set
// - Trim value eight-bit two's complement
// - Rate bit six: zero slow, one fast
// - Trim adds or removes time base ticks
package rotir_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TICK_HZ = 128;
    localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
    localparam logic [6:0] SUB_LAST = 7'h7f;
    localparam logic [5:0] SEC_LAST = 6'h3b;
    localparam logic [5:0] MIN_LAST = 6'h3b;
    localparam logic [4:0] HOUR_LAST = 5'h17;
    localparam logic [1:0] SLOW_PERIOD_MASK = 2'h3;
    localparam logic [2:0] FAST_PERIOD_MASK = 3'h7;
    // Register indices; byte address is four times the index.
    localparam logic [7:0] IDX_TRIM = 8'h24;
    localparam logic [7:0] IDX_OSC = 8'h25;
    localparam logic [7:0] IDX_EN_FIRST = 8'h29;
    localparam logic [7:0] IDX_EN_SECOND = 8'h2a;
    localparam logic [7:0] IDX_PIN_IO = 8'h30;
    localparam logic [7:0] IDX_STATUS = 8'h31;
    localparam logic [7:0] IDX_TIME = 8'h32;
    localparam int unsigned OSC_RATE_BIT = 6;
    localparam int unsigned EN_MODE_BIT = 7;
    localparam int unsigned PIN_FIRST_LSB = 0;
    localparam int unsigned PIN_CAPTURE_LSB = 2;
    localparam int unsigned STAT_MON_BIT = 8;
    localparam logic [1:0] FIRST_MODE_IRQ = 2'h2;
    localparam logic [1:0] CAPTURE_FN_IRQ = 2'h1;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Bit order matches enable bits 6 down to 0.
    typedef struct packed {
        logic periodic;
        logic trim;
        logic alarm_one;
        logic alarm_two;
        logic capture;
        logic supply_switch;
        logic watchdog;
    } rotir_evt_type;

    typedef struct packed {
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
    } rotir_time_type;
endpackage : rotir_pkg

// file: hdl/rotir_irq_pin.sv
// One interrupt output channel: pulse stretcher and level combiner.
// Assumes triggers are one-cycle pulses and flags are levels on the same clock.
`timescale 1ns/10ps
module rotir_irq_pin (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic tick128,
    input wire logic [7:0] enable,
    input wire rotir_pkg::rotir_evt_type trig,
    input wire rotir_pkg::rotir_evt_type flags,
    output logic active
);
    rotir_pkg::rotir_evt_type hit;
    rotir_pkg::rotir_evt_type src_r;
    logic pulse_r;
    logic armed_r;
    logic level_mode;
    logic held;

    assign level_mode = enable[rotir_pkg::EN_MODE_BIT];
    assign hit = trig & enable[6:0];
    // A trim source has no flag, so it only holds the pulse by itself.
    assign held = |(src_r & (flags | 7'h20));

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pulse_r <= 1'b0;
            armed_r <= 1'b0;
            src_r <= '0;
        end else if (|hit) begin
            pulse_r <= 1'b1;
            armed_r <= 1'b0;
            src_r <= hit;
        end else if (pulse_r && (!held || (tick128 && armed_r))) begin
            pulse_r <= 1'b0;
            armed_r <= 1'b0;
            src_r <= '0;
        end else if (pulse_r && tick128) begin
            armed_r <= 1'b1;
        end
    end

    // The trim source is masked out of level mode since it has no flag.
    assign active = level_mode ? |(flags & enable[6:0] & 7'h5f) : pulse_r;
endmodule : rotir_irq_pin

// file: hdl/rotir_top.sv
// Trim pulse scheduler, internal time base and two-pin interrupt router.
// Assumes an APB master on clock and event pulses and flags from local logic.
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
module rotir_top #(
    parameter int unsigned TICK_DIV = rotir_pkg::TICK_DIV
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rotir_pkg::rotir_evt_type evt_trig,
    input wire rotir_pkg::rotir_evt_type evt_flags,
    output logic trim_pulse,
    output logic trim_add,
    output logic irq_out_first_n,
    output logic irq_out_first_oe,
    output logic capture_pin_out,
    output logic capture_pin_oe
);
    logic [7:0] trim_r;
    logic [7:0] osc_r;
    logic [7:0] en_first_r;
    logic [7:0] en_second_r;
    logic [3:0] pin_io_r;
    logic [31:0] div_r;
    logic tick128;
    logic [6:0] sub_r;
    rotir_pkg::rotir_time_type now_r;
    logic [1:0] adj_r;
    logic step;
    logic window;
    logic sec_wrap;
    logic min_wrap;
    logic hour_wrap;
    logic [8:0] mag;
    logic [8:0] left_r;
    logic sign_r;
    logic pulse_r;
    logic add_r;
    rotir_pkg::rotir_evt_type trig_all;
    logic act_first;
    logic act_second;
    logic first_o_r;
    logic second_o_r;
    logic [31:0] rd_r;
    logic err_r;
    logic [7:0] idx;
    logic wr_en;
    logic rd_setup;
    logic refused;
    logic launch;
    logic advance;
    logic first_pin_irq;
    logic capture_pin_irq;

    function automatic logic [8:0] magnitude(input logic [7:0] v);
        logic [8:0] ext;
        ext = {v[7], v};
        magnitude = v[7] ? 9'(-ext) : ext;
    endfunction : magnitude

    function automatic logic mapped(input logic [7:0] i);
        mapped = (i == rotir_pkg::IDX_TRIM) || (i == rotir_pkg::IDX_OSC) ||
                 (i == rotir_pkg::IDX_EN_FIRST) || (i == rotir_pkg::IDX_EN_SECOND) ||
                 (i == rotir_pkg::IDX_PIN_IO) || (i == rotir_pkg::IDX_STATUS) ||
                 (i == rotir_pkg::IDX_TIME);
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////////
    // APB slave. Read data is captured in the setup cycle so prdata comes
    // from a flop; every transfer completes in its first access cycle.
    assign idx = paddr[9:2];
    // Upper address bits are decoded too, so no register shows up at an alias.
    assign refused = !mapped(idx) || (paddr[1:0] != 2'h0) || (paddr[11:10] != 2'h0);
    assign wr_en = psel && penable && pwrite && !refused;
    assign rd_setup = psel && !penable;
    assign pready = psel && penable;
    assign pslverr = psel && penable && err_r;
    assign prdata = rd_r;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            err_r <= 1'b0;
        end else if (rd_setup) begin
            err_r <= refused;
        end
    end

    // A refused read returns zero rather than whatever the index aliases to.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_r <= '0;
        end else if (rd_setup) begin
            if (pwrite || refused) begin
                rd_r <= '0;
            end else if (idx == rotir_pkg::IDX_TRIM) begin
                rd_r <= {24'h0, trim_r};
            end else if (idx == rotir_pkg::IDX_OSC) begin
                rd_r <= {24'h0, osc_r};
            end else if (idx == rotir_pkg::IDX_EN_FIRST) begin
                rd_r <= {24'h0, en_first_r};
            end else if (idx == rotir_pkg::IDX_EN_SECOND) begin
                rd_r <= {24'h0, en_second_r};
            end else if (idx == rotir_pkg::IDX_PIN_IO) begin
                rd_r <= {28'h0, pin_io_r};
            end else if (idx == rotir_pkg::IDX_STATUS) begin
                rd_r <= {23'h0, |evt_flags, left_r[6:0], sign_r};
            end else if (idx == rotir_pkg::IDX_TIME) begin
                rd_r <= {15'h0, now_r};
            end else begin
                rd_r <= '0;
            end
        end
    end

    // Status and time are read-only; a write to them completes and is dropped.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            trim_r <= rotir_pkg::RESET_BYTE;
        end else if (wr_en && idx == rotir_pkg::IDX_TRIM) begin
            trim_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            osc_r <= rotir_pkg::RESET_BYTE;
        end else if (wr_en && idx == rotir_pkg::IDX_OSC) begin
            osc_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            en_first_r <= rotir_pkg::RESET_BYTE;
        end else if (wr_en && idx == rotir_pkg::IDX_EN_FIRST) begin
            en_first_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            en_second_r <= rotir_pkg::RESET_BYTE;
        end else if (wr_en && idx == rotir_pkg::IDX_EN_SECOND) begin
            en_second_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_io_r <= '0;
        end else if (wr_en && idx == rotir_pkg::IDX_PIN_IO) begin
            pin_io_r <= pwdata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time base: a 128 Hz enable and a seconds counter of 128 ticks.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            div_r <= '0;
        end else if (div_r == 32'(TICK_DIV - 1)) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 32'h1;
        end
    end

    assign tick128 = (div_r == 32'(TICK_DIV - 1));

    // A pending add jumps the sub-second count by two ticks and a pending
    // remove holds it for one, so only individual seconds change length.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sub_r <= '0;
        end else if (tick128) begin
            if (adj_r == 2'h1) begin
                sub_r <= sub_r + 7'h2;
            end else if (adj_r == 2'h2) begin
                sub_r <= sub_r;
            end else begin
                sub_r <= sub_r + 7'h1;
            end
        end
    end

    // A pending adjustment is consumed by the next tick; a new pulse wins.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            adj_r <= 2'h0;
        end else if (pulse_r) begin
            adj_r <= add_r ? 2'h1 : 2'h2;
        end else if (tick128) begin
            adj_r <= 2'h0;
        end
    end

    assign sec_wrap = tick128 && (adj_r != 2'h2) &&
                      (sub_r == rotir_pkg::SUB_LAST || (adj_r == 2'h1 && sub_r == 7'h7e));
    assign min_wrap = sec_wrap && (now_r.second == rotir_pkg::SEC_LAST);
    assign hour_wrap = min_wrap && (now_r.minute == rotir_pkg::MIN_LAST);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            now_r <= '0;
        end else if (sec_wrap) begin
            now_r.second <= min_wrap ? 6'h0 : now_r.second + 6'h1;
            if (min_wrap) begin
                now_r.minute <= hour_wrap ? 6'h0 : now_r.minute + 6'h1;
            end
            if (hour_wrap) begin
                now_r.hour <= (now_r.hour == rotir_pkg::HOUR_LAST) ? 5'h0 :
                              now_r.hour + 5'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trim scheduler. Slow mode steps on minutes and triggers entering minute
    // 00 of every fourth hour; fast mode steps on seconds and triggers
    // entering second 00 of every eighth minute from 08 to 56, not of minute 00.
    always_comb begin
        if (osc_r[rotir_pkg::OSC_RATE_BIT]) begin
            step = sec_wrap;
            window = min_wrap &&
                     (((now_r.minute[2:0] + 3'h1) & rotir_pkg::FAST_PERIOD_MASK) == 3'h0);
        end else begin
            step = min_wrap;
            window = hour_wrap &&
                     (((now_r.hour[1:0] + 2'h1) & rotir_pkg::SLOW_PERIOD_MASK) == 2'h0);
        end
    end

    assign mag = magnitude(trim_r);

    // A zero magnitude starts no run, so an unprogrammed trim costs nothing.
    assign launch = window && (mag != 9'h0);
    assign advance = step && (left_r != 9'h0);

    // The magnitude is latched at the trigger, so a write during a run only
    // takes effect at the next trigger.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            left_r <= '0;
        end else if (launch) begin
            left_r <= mag - 9'h1;
        end else if (advance) begin
            left_r <= left_r - 9'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sign_r <= 1'b0;
        end else if (launch) begin
            sign_r <= !trim_r[7];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            add_r <= 1'b0;
        end else if (launch) begin
            add_r <= !trim_r[7];
        end else if (advance) begin
            add_r <= sign_r;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pulse_r <= 1'b0;
        end else begin
            pulse_r <= launch || advance;
        end
    end

    assign trim_pulse = pulse_r;
    assign trim_add = add_r;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt routing.
    always_comb begin
        trig_all = evt_trig;
        trig_all.trim = pulse_r;
    end

    rotir_irq_pin u_first (
        .clock(clock),
        .rst_n(rst_n),
        .tick128(tick128),
        .enable(en_first_r),
        .trig(trig_all),
        .flags(evt_flags),
        .active(act_first)
    );

    rotir_irq_pin u_second (
        .clock(clock),
        .rst_n(rst_n),
        .tick128(tick128),
        .enable(en_second_r),
        .trig(trig_all),
        .flags(evt_flags),
        .active(act_second)
    );

    assign first_pin_irq = (pin_io_r[rotir_pkg::PIN_FIRST_LSB +: 2] ==
                            rotir_pkg::FIRST_MODE_IRQ);
    assign capture_pin_irq = (pin_io_r[rotir_pkg::PIN_CAPTURE_LSB +: 2] ==
                              rotir_pkg::CAPTURE_FN_IRQ);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            first_o_r <= 1'b0;
        end else begin
            first_o_r <= act_first && first_pin_irq;
        end
    end

    // The second channel runs even while the pin serves another function,
    // so switching the pin over shows the current state at once.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            second_o_r <= 1'b0;
        end else begin
            second_o_r <= act_second;
        end
    end

    // Open drain: the pin is only ever pulled low.
    assign irq_out_first_n = 1'b0;
    assign irq_out_first_oe = first_o_r;
    assign capture_pin_oe = capture_pin_irq;
    assign capture_pin_out = !second_o_r;
endmodule : rotir_top

// file: verification/rotir_host_model.sv
// Host-side view of the two interrupt lines.
// Assumes board pull-ups on both lines; the host only reads them.
`timescale 1ns/10ps
module rotir_host_model (
    input wire logic first_n,
    input wire logic first_oe,
    input wire logic second_out,
    input wire logic second_oe,
    output logic first_line,
    output logic second_line
);
    // The open-drain line is only ever pulled low, the pull-up gives the high level.
    assign first_line = first_oe ? first_n : 1'b1;
    assign second_line = second_oe ? second_out : 1'b1;
endmodule : rotir_host_model

// file: verification/rotir_checker.sv
// Port-level checks of the trim scheduler and interrupt router.
// Assumes it is bound to the top module and shadows configuration from APB writes.
`timescale 1ns/10ps
module rotir_checker #(
    parameter int unsigned TICK_DIV = 1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire rotir_pkg::rotir_evt_type evt_trig,
    input wire rotir_pkg::rotir_evt_type evt_flags,
    input wire logic trim_pulse,
    input wire logic trim_add,
    input wire logic irq_out_first_n,
    input wire logic irq_out_first_oe,
    input wire logic capture_pin_out,
    input wire logic capture_pin_oe
);
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow copies avoid peeking inside the design.
    logic [7:0] en_a_r;
    logic [7:0] en_b_r;
    logic [3:0] pin_r;
    logic [6:0] trig_v;
    logic [6:0] flag_v;
    assign trig_v = evt_trig;
    assign flag_v = evt_flags;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            en_a_r <= 8'h00;
            en_b_r <= 8'h00;
            pin_r <= 4'h0;
        end else if (psel && penable && pwrite && !pslverr) begin
            case (paddr)
                12'h0a4: en_a_r <= pwdata[7:0];
                12'h0a8: en_b_r <= pwdata[7:0];
                12'h0c0: pin_r <= pwdata[3:0];
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_first_off;
        pin_r[1:0] != 2'h2 ##1 pin_r[1:0] != 2'h2;
    endsequence
    sequence s_pulse_cause;
        !en_a_r[7] && pin_r[1:0] == 2'h2 && |(trig_v & en_a_r[6:0] & 7'h5f);
    endsequence
    a_first_open_drain: assert property (irq_out_first_n == 1'b0)
        else $error("first output drives high");
    a_first_gated: assert property (s_first_off |-> !irq_out_first_oe)
        else $error("first output active outside interrupt mode");
    a_capture_oe_mode: assert property ($past(pin_r) == pin_r |->
        capture_pin_oe == (pin_r[3:2] == 2'h1)) else $error("capture pin drive wrong");
    a_pulse_follows: assert property (s_pulse_cause |-> ##2 irq_out_first_oe)
        else $error("no pulse after enabled trigger");
    a_level_second: assert property (en_b_r[7] && pin_r[3:2] == 2'h1 && $stable(en_b_r)
        |=> capture_pin_out == !$past(|(flag_v & en_b_r[6:0] & 7'h5f)))
        else $error("level output not the enabled flags");
    a_trim_irq_second: assert property (trim_pulse && en_b_r[7:5] == 3'h1 &&
        pin_r[3:2] == 2'h1 |-> ##[0:3] !capture_pin_out) else $error("no trim interrupt");
    a_trim_spacing: assert property (trim_pulse |=> !trim_pulse [*8])
        else $error("trim pulses too close");
    a_pready_now: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    a_err_in_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
endmodule : rotir_checker

// file: verification/rotir_top_tb.sv
// Self-checking bench for the trim scheduler and interrupt router.
// Assumes the checker and host model are compiled before this file.
`timescale 1ns/10ps
module rotir_top_tb;
    localparam logic [7:0] EA = rotir_pkg::IDX_EN_FIRST;
    localparam logic [7:0] EB = rotir_pkg::IDX_EN_SECOND;
    localparam logic [7:0] ST = rotir_pkg::IDX_STATUS;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    rotir_pkg::rotir_evt_type evt_trig, evt_flags;
    logic trim_pulse, trim_add, first_n, first_oe, cap_out, cap_oe, first_line, second_line;
    int n_fail, checked;
    ////////////////////////////////////////////////////////////////////////////////
    // A divider of one keeps the eighth-minute trigger within a short run.
    rotir_top #(.TICK_DIV(1)) u_rotir_top (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .evt_trig(evt_trig), .evt_flags(evt_flags),
        .trim_pulse(trim_pulse), .trim_add(trim_add), .irq_out_first_n(first_n),
        .irq_out_first_oe(first_oe), .capture_pin_out(cap_out), .capture_pin_oe(cap_oe));
    rotir_host_model u_rotir_host_model (.first_n(first_n), .first_oe(first_oe),
        .second_out(cap_out), .second_oe(cap_oe), .first_line(first_line),
        .second_line(second_line));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_fail++;
            close_out();
        end
    endtask : apb
    task automatic wait_line(input bit second, input logic lvl, input int lim, output bit hit);
        hit = 0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(posedge clock);
            hit = ((second ? second_line : first_line) === lvl);
        end
    endtask : wait_line
    task automatic fire(input logic [6:0] t);
        @(posedge clock);
        evt_trig <= t;
        @(posedge clock);
        evt_trig <= 7'h00;
    endtask : fire
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        apb(1'b0, EA, 32'h0);
        chk("enable first", rd, 32'h0);
        apb(1'b1, EB, 32'h5a);
        apb(1'b0, EB, 32'h0);
        chk("enable second", rd, 32'h5a);
        apb(1'b1, 8'h3f, 32'hff);
        chk("unmapped error", err, 1'b1);
        apb(1'b1, EB, 32'h0);
    endtask : t_regs
    task automatic t_pulse();
        bit hit;
        logic [6:0] src [6] = '{7'h40, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01};
        apb(1'b1, EA, 32'h10);
        fire(7'h10);
        wait_line(1'b0, 1'b0, 8, hit);
        chk("first gated", hit, 1'b0);
        apb(1'b1, rotir_pkg::IDX_PIN_IO, 32'h6);
        @(posedge clock);
        chk("capture enabled", cap_oe, 1'b1);
        foreach (src[i]) begin
            apb(1'b1, EA, {25'h0, src[i]});
            evt_flags <= src[i];
            repeat (2) begin
                fire(src[i]);
                wait_line(1'b0, 1'b0, 6, hit);
                chk("first pulse", hit, 1'b1);
                wait_line(1'b0, 1'b1, 12, hit);
                chk("pulse ends", hit, 1'b1);
            end
            chk("second idle", second_line, 1'b1);
        end
        evt_flags <= 7'h00;
        apb(1'b1, EA, 32'h0);
    endtask : t_pulse
    task automatic t_level();
        bit hit;
        apb(1'b1, EB, 32'h88);
        evt_flags <= 7'h40;
        apb(1'b0, ST, 32'h0);
        chk("level ignores disabled", second_line, 1'b1);
        chk("monitor set", rd[rotir_pkg::STAT_MON_BIT], 1'b1);
        evt_flags <= 7'h48;
        wait_line(1'b1, 1'b0, 4, hit);
        chk("level asserts", hit, 1'b1);
        repeat (20) @(posedge clock);
        chk("level holds", second_line, 1'b0);
        evt_flags <= 7'h00;
        wait_line(1'b1, 1'b1, 4, hit);
        chk("level releases", hit, 1'b1);
        apb(1'b0, ST, 32'h0);
        chk("monitor clear", rd[rotir_pkg::STAT_MON_BIT], 1'b0);
        apb(1'b1, EB, 32'h20);
    endtask : t_level
    task automatic t_trim();
        bit hit;
        int n;
        apb(1'b1, rotir_pkg::IDX_TRIM, 32'hfe);
        apb(1'b1, rotir_pkg::IDX_OSC, 32'h40);
        for (n = 0; n < 70000 && trim_pulse !== 1'b1; n++) @(posedge clock);
        chk("trim start", trim_pulse, 1'b1);
        if (trim_pulse !== 1'b1) begin
            close_out();
        end
        chk("trim removes", trim_add, 1'b0);
        wait_line(1'b1, 1'b0, 6, hit);
        chk("trim irq", hit, 1'b1);
        apb(1'b0, rotir_pkg::IDX_TIME, 32'h0);
        chk("trim time", rd, 32'h200);
        n = 1;
        repeat (400) begin
            @(posedge clock);
            n += (trim_pulse === 1'b1);
        end
        chk("trim count", n, 2);
    endtask : t_trim
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        {n_fail, checked, rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {evt_trig, evt_flags} = '0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        t_regs();
        t_pulse();
        t_level();
        t_trim();
        close_out();
    end
endmodule : rotir_top_tb
bind rotir_top rotir_checker #(.TICK_DIV(TICK_DIV)) u_rotir_checker (.clock(clock),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evt_trig(evt_trig), .evt_flags(evt_flags), .trim_pulse(trim_pulse),
    .trim_add(trim_add), .irq_out_first_n(irq_out_first_n),
    .irq_out_first_oe(irq_out_first_oe), .capture_pin_out(capture_pin_out),
    .capture_pin_oe(capture_pin_oe));
